// File: hdl/adc_input_gain_config_regs.sv
// Chosen here: register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none

module adc_input_gain_config_regs
  import adc_cfg_pkg::*;
#(
  parameter int MOD_DIV = MOD_DIV_DEFAULT
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                cyc_i,
  input  wire logic                stb_i,
  input  wire logic                we_i,
  input  wire logic [WB_ADR_W-1:0] adr_i,
  input  wire logic [WB_SEL_W-1:0] sel_i,
  input  wire logic [WB_DAT_W-1:0] dat_i,
  output logic      [WB_DAT_W-1:0] dat_o,
  output logic                     ack_o,
  output logic      [3:0]          positive_input_select_o,
  output logic      [3:0]          negative_input_select_o,
  output logic      [1:0]          amp_enable_mode_o,
  output logic      [2:0]          gain_code_o,
  output logic                     global_chop_o,
  output logic                     clock_source_o,
  output logic                     single_shot_o,
  output logic                     low_latency_filter_o,
  output logic      [3:0]          output_rate_code_o,
  output logic                     delay_busy_o,
  output logic                     first_conv_start_o
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [REG_W-1:0]     input_channel_select_ff;
  logic [REG_W-1:0]     amp_gain_delay_config_ff;
  logic [REG_W-1:0]     sample_rate_config_ff;
  logic [WB_DAT_W-1:0]  dat_ff;
  logic                 ack_ff;
  logic [15:0]          mod_cnt_ff;
  logic [DLY_CNT_W-1:0] dly_cnt_ff;
  logic                 busy_ff;
  logic                 start_ff;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire              req       = cyc_i & stb_i & ~ack_ff;
  wire [IDX_W-1:0]  idx       = adr_i[WB_ADR_W-1:2];
  wire              wr_lane   = req & we_i & sel_i[0];
  wire              hit_in    = (idx == IDX_INPUT_SEL);
  wire              hit_amp   = (idx == IDX_AMP_CFG);
  wire              hit_rate  = (idx == IDX_RATE_CFG);
  wire              hit_stat  = (idx == IDX_DLY_STAT);
  wire              wr_in     = wr_lane & hit_in;
  wire              wr_amp    = wr_lane & hit_amp;
  wire              wr_rate   = wr_lane & hit_rate;
  wire [REG_W-1:0]  wr_byte   = dat_i[REG_W-1:0];
  wire              filt_rst  = wr_in | wr_amp | wr_rate;
  wire [REG_W-1:0]  stat_byte = {{(REG_W-1){1'b0}}, busy_ff};

  wire [REG_W-1:0]  rd_byte = hit_in   ? input_channel_select_ff :
                              hit_amp  ? amp_gain_delay_config_ff :
                              hit_rate ? sample_rate_config_ff :
                              hit_stat ? stat_byte : {REG_W{1'b0}};
  wire [WB_DAT_W-1:0] nxt_dat = {{(WB_DAT_W-REG_W){1'b0}}, rd_byte};

  // ---------------------------------------------------------------
  // delay selection
  // ---------------------------------------------------------------
  wire [2:0] dly_code = wr_amp ? wr_byte[DLY_HI:DLY_LO] : amp_gain_delay_config_ff[DLY_HI:DLY_LO];
  wire [DLY_CNT_W-1:0] dly_load = (dly_code == 3'h0) ? DLY_P0 :
                                  (dly_code == 3'h1) ? DLY_P1 :
                                  (dly_code == 3'h2) ? DLY_P2 :
                                  (dly_code == 3'h3) ? DLY_P3 :
                                  (dly_code == 3'h4) ? DLY_P4 :
                                  (dly_code == 3'h5) ? DLY_P5 :
                                  (dly_code == 3'h6) ? DLY_P6 : DLY_P7;

  // ---------------------------------------------------------------
  // modulator period enable
  // ---------------------------------------------------------------
  localparam logic [15:0] MOD_LAST = 16'(MOD_DIV - 1);
  wire mod_tick = (mod_cnt_ff == MOD_LAST);
  wire [15:0] nxt_mod_cnt = mod_tick ? 16'h0000 : mod_cnt_ff + 16'h0001;

  wire dly_done = busy_ff & ~filt_rst & mod_tick & (dly_cnt_ff == {{(DLY_CNT_W-1){1'b0}}, 1'b1});
  wire [DLY_CNT_W-1:0] nxt_dly_cnt = filt_rst ? dly_load :
                                     (busy_ff & mod_tick) ? dly_cnt_ff - {{(DLY_CNT_W-1){1'b0}}, 1'b1} :
                                     dly_cnt_ff;
  wire nxt_busy = filt_rst | (busy_ff & ~dly_done);

  // ---------------------------------------------------------------
  // next register values
  // ---------------------------------------------------------------
  // reserved channel and amplifier codes stored as written
  wire [REG_W-1:0]    nxt_input_channel_select  = wr_in ? wr_byte : input_channel_select_ff;
  wire [REG_W-1:0]    nxt_amp_gain_delay_config = wr_amp ? wr_byte : amp_gain_delay_config_ff;
  wire [REG_W-1:0]    nxt_sample_rate_config    = wr_rate ? wr_byte : sample_rate_config_ff;
  wire [WB_DAT_W-1:0] nxt_rd_dat                = req ? nxt_dat : dat_ff;
  wire                nxt_ack                   = req;
  wire                nxt_start                 = dly_done;

  // ---------------------------------------------------------------
  // bus acknowledge
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= nxt_ack;
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_ff <= {WB_DAT_W{1'b0}};
    end else begin
      dat_ff <= nxt_rd_dat;
    end
  end

  // ---------------------------------------------------------------
  // input select register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      input_channel_select_ff <= RST_INPUT_SEL;
    end else begin
      input_channel_select_ff <= nxt_input_channel_select;
    end
  end

  // ---------------------------------------------------------------
  // amplifier register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      amp_gain_delay_config_ff <= RST_AMP_CFG;
    end else begin
      amp_gain_delay_config_ff <= nxt_amp_gain_delay_config;
    end
  end

  // ---------------------------------------------------------------
  // rate register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sample_rate_config_ff <= RST_RATE_CFG;
    end else begin
      sample_rate_config_ff <= nxt_sample_rate_config;
    end
  end

  // ---------------------------------------------------------------
  // modulator period divider
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mod_cnt_ff <= 16'h0000;
    end else begin
      mod_cnt_ff <= nxt_mod_cnt;
    end
  end

  // ---------------------------------------------------------------
  // conversion delay counter
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dly_cnt_ff <= {DLY_CNT_W{1'b0}};
    end else begin
      dly_cnt_ff <= nxt_dly_cnt;
    end
  end

  // ---------------------------------------------------------------
  // delay busy flag
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= nxt_busy;
    end
  end

  // ---------------------------------------------------------------
  // first conversion pulse
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_ff <= 1'b0;
    end else begin
      start_ff <= nxt_start;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign dat_o                   = dat_ff;
  assign ack_o                   = ack_ff;
  assign positive_input_select_o = input_channel_select_ff[POS_SEL_HI:POS_SEL_LO];
  assign negative_input_select_o = input_channel_select_ff[NEG_SEL_HI:NEG_SEL_LO];
  assign amp_enable_mode_o       = amp_gain_delay_config_ff[AMP_EN_HI:AMP_EN_LO];
  assign gain_code_o             = amp_gain_delay_config_ff[GAIN_HI:GAIN_LO];
  assign global_chop_o           = sample_rate_config_ff[CHOP_BIT];
  assign clock_source_o          = sample_rate_config_ff[CLK_SRC_BIT];
  assign single_shot_o           = sample_rate_config_ff[MODE_BIT];
  assign low_latency_filter_o    = sample_rate_config_ff[FILTER_BIT];
  assign output_rate_code_o      = sample_rate_config_ff[RATE_HI:RATE_LO];
  assign delay_busy_o            = busy_ff;
  assign first_conv_start_o      = start_ff;

endmodule

`default_nettype wire

// File: hdl/adc_cfg_pkg.sv
package adc_cfg_pkg;

  // ---------------------------------------------------------------
  // bus geometry
  // ---------------------------------------------------------------
  localparam int          WB_ADR_W = 8;
  localparam int          WB_DAT_W = 32;
  localparam int          WB_SEL_W = 4;
  localparam int          REG_W    = 8;
  localparam int          IDX_W    = WB_ADR_W - 2;

  // ---------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ---------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_INPUT_SEL = 6'h02;
  localparam logic [IDX_W-1:0] IDX_AMP_CFG   = 6'h03;
  localparam logic [IDX_W-1:0] IDX_RATE_CFG  = 6'h04;
  localparam logic [IDX_W-1:0] IDX_DLY_STAT  = 6'h05;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [REG_W-1:0] RST_INPUT_SEL = 8'h01;
  localparam logic [REG_W-1:0] RST_AMP_CFG   = 8'h00;
  localparam logic [REG_W-1:0] RST_RATE_CFG  = 8'h14;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int POS_SEL_HI   = 7;
  localparam int POS_SEL_LO   = 4;
  localparam int NEG_SEL_HI   = 3;
  localparam int NEG_SEL_LO   = 0;
  localparam int DLY_HI       = 7;
  localparam int DLY_LO       = 5;
  localparam int AMP_EN_HI    = 4;
  localparam int AMP_EN_LO    = 3;
  localparam int GAIN_HI      = 2;
  localparam int GAIN_LO      = 0;
  localparam int CHOP_BIT     = 7;
  localparam int CLK_SRC_BIT  = 6;
  localparam int MODE_BIT     = 5;
  localparam int FILTER_BIT   = 4;
  localparam int RATE_HI      = 3;
  localparam int RATE_LO      = 0;

  // ---------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------
  localparam logic [3:0] CH_LAST_ANALOG = 4'hB;
  localparam logic [3:0] CH_COMMON      = 4'hC;
  localparam logic [1:0] AMP_BYPASS     = 2'h0;
  localparam logic [1:0] AMP_ACTIVE     = 2'h1;
  localparam logic       MODE_CONT      = 1'h0;

  // ---------------------------------------------------------------
  // conversion delay in modulator periods
  // ---------------------------------------------------------------
  localparam int          DLY_CNT_W = 13;
  localparam logic [DLY_CNT_W-1:0] DLY_P0 = 13'h000E;
  localparam logic [DLY_CNT_W-1:0] DLY_P1 = 13'h0019;
  localparam logic [DLY_CNT_W-1:0] DLY_P2 = 13'h0040;
  localparam logic [DLY_CNT_W-1:0] DLY_P3 = 13'h0100;
  localparam logic [DLY_CNT_W-1:0] DLY_P4 = 13'h0400;
  localparam logic [DLY_CNT_W-1:0] DLY_P5 = 13'h0800;
  localparam logic [DLY_CNT_W-1:0] DLY_P6 = 13'h1000;
  localparam logic [DLY_CNT_W-1:0] DLY_P7 = 13'h1000;

  localparam int MOD_DIV_DEFAULT = 16;

endpackage

// File: dv/adc_cfg_properties.sv
`timescale 1ns/1ns
`default_nettype none
module adc_cfg_checker
  import adc_cfg_pkg::*;
#(
  parameter int MOD_DIV = MOD_DIV_DEFAULT
) (
  input wire logic                clk_i,
  input wire logic                rst_i,
  input wire logic                cyc_i,
  input wire logic                stb_i,
  input wire logic                we_i,
  input wire logic [WB_ADR_W-1:0] adr_i,
  input wire logic [WB_SEL_W-1:0] sel_i,
  input wire logic [WB_DAT_W-1:0] dat_i,
  input wire logic [WB_DAT_W-1:0] dat_o,
  input wire logic                ack_o,
  input wire logic [3:0]          positive_input_select_o,
  input wire logic [3:0]          negative_input_select_o,
  input wire logic [1:0]          amp_enable_mode_o,
  input wire logic [2:0]          gain_code_o,
  input wire logic                global_chop_o,
  input wire logic                clock_source_o,
  input wire logic                single_shot_o,
  input wire logic                low_latency_filter_o,
  input wire logic [3:0]          output_rate_code_o,
  input wire logic                delay_busy_o,
  input wire logic                first_conv_start_o
);
  wire logic             taken  = cyc_i && stb_i && !ack_o;
  wire logic [IDX_W-1:0] idx    = adr_i[WB_ADR_W-1:2];
  wire logic [7:0]       sel_v  = {positive_input_select_o, negative_input_select_o};
  wire logic [4:0]       amp_v  = {amp_enable_mode_o, gain_code_o};
  wire logic [7:0]       rate_v = {global_chop_o, clock_source_o, single_shot_o, low_latency_filter_o,
                                   output_rate_code_o};
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_wr(logic [IDX_W-1:0] i);
    taken && we_i && sel_i[0] && idx == i;
  endsequence
  sequence s_rd(logic [IDX_W-1:0] i);
    ack_o && !we_i && idx == i;
  endsequence
  a_reset_values: assert property (disable iff (1'b0) rst_i |=> !ack_o && !delay_busy_o &&
    sel_v == RST_INPUT_SEL && amp_v == 5'h00 && rate_v == RST_RATE_CFG) else $error("reset values wrong");
  a_sel_write: assert property (s_wr(IDX_INPUT_SEL) |=> sel_v == $past(dat_i[7:0]))
    else $error("input select write lost");
  a_amp_write: assert property (s_wr(IDX_AMP_CFG) |=> amp_v == $past(dat_i[4:0]))
    else $error("amplifier write lost");
  a_rate_write: assert property (s_wr(IDX_RATE_CFG) |=> rate_v == $past(dat_i[7:0]))
    else $error("rate write lost");
  a_sel_read: assert property (s_rd(IDX_INPUT_SEL) |-> dat_o == {24'h000000, sel_v})
    else $error("input select read wrong");
  a_amp_read: assert property (s_rd(IDX_AMP_CFG) |-> dat_o[4:0] == amp_v && dat_o[31:8] == 24'h0)
    else $error("amplifier read wrong");
  a_rate_read: assert property (s_rd(IDX_RATE_CFG) |-> dat_o == {24'h000000, rate_v})
    else $error("rate read wrong");
  a_busy_on_write: assert property (taken && we_i && sel_i[0] && idx inside {[2:4]} |=> delay_busy_o)
    else $error("delay not started by write");
  a_start_pulse: assert property (first_conv_start_o |-> $past(delay_busy_o) && !delay_busy_o
    ##1 !first_conv_start_o) else $error("start pulse malformed");
  a_min_delay: assert property ($rose(delay_busy_o) |=> (!first_conv_start_o)[*8])
    else $error("conversion delay too short");
endmodule
bind adc_input_gain_config_regs adc_cfg_checker #(.MOD_DIV(MOD_DIV)) u_chk (.*);
`default_nettype wire

// File: dv/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  import adc_cfg_pkg::*;
  localparam int MD = 2;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i;
  logic [7:0]  adr_i, s, m;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, q;
  wire logic [31:0] dat_o;
  wire logic        ack_o, busy, start, chop, csrc, ss, filt;
  wire logic [3:0]  pos, neg, rate;
  wire logic [1:0]  amp;
  wire logic [2:0]  gain;
  int num_errors = 0;
  int num_checks = 0;
  adc_input_gain_config_regs #(.MOD_DIV(MD)) uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .positive_input_select_o(pos), .negative_input_select_o(neg), .amp_enable_mode_o(amp), .gain_code_o(gain),
    .global_chop_o(chop), .clock_source_o(csrc), .single_shot_o(ss), .low_latency_filter_o(filt),
    .output_rate_code_o(rate), .delay_busy_o(busy), .first_conv_start_o(start));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task stop_test;
    if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] b);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= {24'h000000, d};
    sel_i <= b;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic rdchk(input string n, input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, 4'hF);
    chk(n, {24'h000000, e}, q);
  endtask
  task automatic t_reset;
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk("sel", 8'h08, 8'h01);
    rdchk("amp", 8'h0C, 8'h00);
    rdchk("rate", 8'h10, 8'h14);
    chk("ports", {9'h000, 8'h01, 5'h00, 8'h14, 2'h0}, {9'h000, pos, neg, amp, gain, chop, csrc, ss, filt, rate, busy, start});
  endtask
  task automatic t_regs;
    for (int i = 0; i < 32; i++) begin
      s = {i[3:0], ~i[3:0]};
      m = {i[2:0], i[4:3], (i[4:3] == 2'h0) ? 3'h0 : i[2:0]};
      bus(1'b1, 8'h08, s, 4'hF);
      bus(1'b1, 8'h0C, m, 4'hF);
      bus(1'b1, 8'h10, s, 4'hF);
      rdchk("sel", 8'h08, s);
      rdchk("amp", 8'h0C, m);
      rdchk("rate", 8'h10, s);
      chk("ports", {11'h000, s, m[4:0], s}, {11'h000, pos, neg, amp, gain, chop, csrc, ss, filt, rate});
    end
    bus(1'b1, 8'h0C, 8'h00, 4'hE);
    rdchk("amp no byte", 8'h0C, m);
    bus(1'b1, 8'h20, 8'hFF, 4'hF);
    rdchk("unmapped", 8'h20, 8'h00);
    rdchk("status", 8'h14, 8'h01);
  endtask
  task automatic t_delay;
    int n;
    int tk[9] = '{14, 25, 64, 256, 1024, 2048, 4096, 4096, 14};
    for (int c = 0; c < 9; c++) begin
      if (c == 8) begin
        bus(1'b1, 8'h0C, 8'h00, 4'hF);
        repeat (10) @(posedge clk_i);
      end
      bus(1'b1, 8'h0C, {c[2:0], 5'h00}, 4'hF);
      n = 0;
      do begin
        @(posedge clk_i);
        n++;
      end while (start !== 1'b1 && n < 20000);
      chk("delay", 32'h1, {31'h0, n >= tk[c] * MD - MD - 1 && n <= tk[c] * MD + MD});
      chk("busy end", 32'h0, {31'h0, busy});
    end
  endtask
  initial begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i  = 1'b0;
    adr_i = 8'h00;
    sel_i = 4'h0;
    dat_i = 32'h0;
    t_reset;
    t_regs;
    t_reset;
    t_delay;
    stop_test;
  end
  initial begin
    repeat (60000) @(posedge clk_i);
    num_errors++;
    stop_test;
  end
endmodule
`default_nettype wire
